// ---- verilog/tpdo_defs.svh ----
// Constants for the transmit PDO communication parameter block.
`ifndef TPDO_DEFS_SVH
`define TPDO_DEFS_SVH

// ==========================================================================
// Channels and record layout
`define TPDO_NCH          4
`define TPDO_NCH_LAST     2'h3
`define TPDO_ENTRY_COUNT  32'h0000_0006
`define TPDO_FLD_COUNT    3'h0
`define TPDO_FLD_COB      3'h1
`define TPDO_FLD_TTYPE    3'h2
`define TPDO_FLD_INHIBIT  3'h3
`define TPDO_FLD_COMPAT   3'h4
`define TPDO_FLD_EVTIMER  3'h5
`define TPDO_FLD_SSTART   3'h6
`define TPDO_FLD_NONE     3'h7

// ==========================================================================
// Byte addresses: channel c field f at c*0x20 + f*4, globals from 0x80
`define TPDO_ADDR_GLOBAL_BIT 7
`define TPDO_GREG_CTRL    5'h00
`define TPDO_GREG_OVF     5'h01
`define TPDO_GREG_STATUS  5'h02
`define TPDO_CTRL_STORE   0
`define TPDO_CTRL_RESTORE 1

// ==========================================================================
// Reset values
`define TPDO_RST_COB      32'h0000_0000
`define TPDO_RST_TTYPE    8'hFF
`define TPDO_RST_INHIBIT  16'h0064
`define TPDO_RST_COMPAT   8'h00
`define TPDO_RST_EVTIMER  16'h0000
`define TPDO_RST_SSTART   8'h00
`define TPDO_RST_OVF      8'h00

// ==========================================================================
// Transmission type codes
`define TPDO_TT_ACYCLIC   8'h00
`define TPDO_TT_SYNC_MAX  8'hF0
`define TPDO_TT_ASYNC_A   8'hFE
`define TPDO_TT_ASYNC_B   8'hFF

// ==========================================================================
// Timing
`define TPDO_CLK_NS       20
`define TPDO_INH_UNIT_NS  100000
`define TPDO_EVT_UNIT_NS  1000000
`define TPDO_TICK_CYC     ((`TPDO_INH_UNIT_NS+`TPDO_CLK_NS-1)/`TPDO_CLK_NS)
`define TPDO_MS_DIV       (`TPDO_EVT_UNIT_NS/`TPDO_INH_UNIT_NS)

`endif

// ---- verilog/tpdo_pkg.sv ----
// Types shared by the transmit PDO parameter block.
`include "tpdo_defs.svh"

package tpdo_pkg;

   typedef logic [1:0] tpdo_ch_t;
   typedef logic [2:0] tpdo_fld_t;

   typedef enum logic [2:0] {
      TPDO_NV_IDLE  = 3'b000,
      TPDO_NV_ST_RD = 3'b001,
      TPDO_NV_ST_WR = 3'b010,
      TPDO_NV_RS_RD = 3'b011,
      TPDO_NV_RS_WR = 3'b100
   } tpdo_nv_e;

   typedef struct packed {
      logic [`TPDO_NCH-1:0][31:0] cob;
      logic [`TPDO_NCH-1:0][7:0]  ttype;
      logic [`TPDO_NCH-1:0][15:0] inh;
      logic [`TPDO_NCH-1:0][7:0]  compat;
      logic [`TPDO_NCH-1:0][15:0] evt;
      logic [`TPDO_NCH-1:0][7:0]  sstart;
      logic [31:0]                rdata;
   } tpdo_mem_s;

endpackage

// ---- verilog/tpdo_mem_if.sv ----
// Link between the trigger logic and the parameter store.
`timescale 1ns/1ps
`include "tpdo_defs.svh"

interface tpdo_mem_if;
   logic                       we;
   logic [1:0]                 wch;
   logic [2:0]                 wfld;
   logic [31:0]                wdata;
   logic [1:0]                 rch;
   logic [2:0]                 rfld;
   logic [31:0]                rdata;
   logic [`TPDO_NCH-1:0][31:0] cob;
   logic [`TPDO_NCH-1:0][7:0]  ttype;
   logic [`TPDO_NCH-1:0][15:0] inh;
   logic [`TPDO_NCH-1:0][15:0] evt;
   logic [`TPDO_NCH-1:0][7:0]  sstart;

   modport store (input  we, wch, wfld, wdata, rch, rfld,
                  output rdata, cob, ttype, inh, evt, sstart);
   modport user  (output we, wch, wfld, wdata, rch, rfld,
                  input  rdata, cob, ttype, inh, evt, sstart);
endinterface

// ---- verilog/tpdo_param_mem.sv ----
// Parameter records of all transmit channels, with a registered read port.
`timescale 1ns/1ps
`include "tpdo_defs.svh"

module tpdo_param_mem
   import tpdo_pkg::*;
(
   // Clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_reset,
   // Access port
   tpdo_mem_if.store m
);

   tpdo_mem_s q;
   tpdo_mem_s d;

   function automatic logic [31:0] rd_field(input tpdo_mem_s s,
                                            input tpdo_ch_t  c,
                                            input tpdo_fld_t f);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (f)
         `TPDO_FLD_COUNT:   v = `TPDO_ENTRY_COUNT;
         `TPDO_FLD_COB:     v = s.cob[c];
         `TPDO_FLD_TTYPE:   v = {24'h000000, s.ttype[c]};
         `TPDO_FLD_INHIBIT: v = {16'h0000, s.inh[c]};
         `TPDO_FLD_COMPAT:  v = {24'h000000, s.compat[c]};
         `TPDO_FLD_EVTIMER: v = {16'h0000, s.evt[c]};
         `TPDO_FLD_SSTART:  v = {24'h000000, s.sstart[c]};
         `TPDO_FLD_NONE:    v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   always_comb begin
      d = q;
      d.rdata = rd_field(q, m.rch, m.rfld);
      if (m.we) begin
         unique case (m.wfld)
            `TPDO_FLD_COB:     d.cob[m.wch]    = m.wdata;
            `TPDO_FLD_TTYPE:   d.ttype[m.wch]  = m.wdata[7:0];
            `TPDO_FLD_INHIBIT: d.inh[m.wch]    = m.wdata[15:0];
            `TPDO_FLD_COMPAT:  d.compat[m.wch] = m.wdata[7:0];
            `TPDO_FLD_EVTIMER: d.evt[m.wch]    = m.wdata[15:0];
            `TPDO_FLD_SSTART:  d.sstart[m.wch] = m.wdata[7:0];
            default:           d.rdata         = d.rdata;
         endcase
      end
      if (i_reset) begin
         // Every channel starts from the same record.
         for (int i = 0; i < `TPDO_NCH; i++) begin
            d.cob[i]    = `TPDO_RST_COB;
            d.ttype[i]  = `TPDO_RST_TTYPE;
            d.inh[i]    = `TPDO_RST_INHIBIT;
            d.compat[i] = `TPDO_RST_COMPAT;
            d.evt[i]    = `TPDO_RST_EVTIMER;
            d.sstart[i] = `TPDO_RST_SSTART;
         end
         d.rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      q <= d;
   end

   assign m.rdata  = q.rdata;
   assign m.cob    = q.cob;
   assign m.ttype  = q.ttype;
   assign m.inh    = q.inh;
   assign m.evt    = q.evt;
   assign m.sstart = q.sstart;

endmodule

// ---- verilog/tpdo_comm_params.sv ----
// Transmit PDO parameter registers, send triggers and parameter save.
`timescale 1ns/1ps
`include "tpdo_defs.svh"

// How it works
// - entry count reads six, read only
// - per-channel 32-bit identifier, reset zero
// - per-channel transmission type, reset FF
// - inhibit time in 100 us, reset 0064
// - inhibit applies to asynchronous channels only
// - compatibility entry stored, no effect
// - event timer in ms triggers send
// - first send waits for sync start count
// - afterwards only transmission type governs sends
// - sync start active only if overflow above 1
// - four independent identical channel records
// - records saved to and restored from NV
module tpdo_comm_params
   import tpdo_pkg::*;
#(
   parameter int P_TICK_CYC = `TPDO_TICK_CYC
)(
   // Clock and reset
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_reset,
   // APB slave
   input  wire logic                 i_psel,
   input  wire logic                 i_penable,
   input  wire logic                 i_pwrite,
   input  wire logic [7:0]           i_paddr,
   input  wire logic [31:0]          i_pwdata,
   output logic                      o_pready,
   output logic                      o_pslverr,
   output logic [31:0]               o_prdata,
   // Sync and application events
   input  wire logic                 i_sync,
   input  wire logic [7:0]           i_sync_count,
   input  wire logic [`TPDO_NCH-1:0] i_app_event,
   // Send request toward the frame sender
   output logic                      o_tx_valid,
   output logic [1:0]                o_tx_chan,
   output logic [31:0]               o_tx_cob,
   input  wire logic                 i_tx_ready,
   // Non-volatile parameter store
   output logic                      o_nv_we,
   output logic                      o_nv_re,
   output logic [4:0]                o_nv_addr,
   output logic [31:0]               o_nv_wdata,
   input  wire logic [31:0]          i_nv_rdata
);

   typedef struct packed {
      tpdo_nv_e                   nv;
      tpdo_ch_t                   nv_ch;
      tpdo_fld_t                  nv_fld;
      logic [12:0]                tick;
      logic [3:0]                 msdiv;
      logic [7:0]                 ovf;
      logic                       rd_ok;
      logic [`TPDO_NCH-1:0][16:0] inh;
      logic [`TPDO_NCH-1:0][15:0] evt;
      logic [`TPDO_NCH-1:0][7:0]  scnt;
      logic [`TPDO_NCH-1:0]       started;
      logic [`TPDO_NCH-1:0]       apend;
      logic [`TPDO_NCH-1:0]       spend;
      logic [`TPDO_NCH-1:0]       zpend;
      logic                       tx_valid;
      tpdo_ch_t                   tx_chan;
      logic [31:0]                tx_cob;
   } tpdo_top_s;

   tpdo_top_s q;
   tpdo_top_s d;

   tpdo_mem_if m ();

   tpdo_param_mem u_mem (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .m         (m)
   );

   function automatic logic tt_async(input logic [7:0] tt);
      return (tt == `TPDO_TT_ASYNC_A) || (tt == `TPDO_TT_ASYNC_B);
   endfunction

   function automatic logic tt_cyclic(input logic [7:0] tt);
      return (tt != `TPDO_TT_ACYCLIC) && (tt <= `TPDO_TT_SYNC_MAX);
   endfunction

   // ==========================================================================
   // APB decode
   logic      acc;
   logic      busy;
   logic      glob;
   logic      unmapped;
   logic      wr;
   logic      ch_wr;
   tpdo_ch_t  a_ch;
   tpdo_fld_t a_fld;
   logic      nv_restore_wr;
   logic [4:0] greg;

   assign acc      = i_psel & i_penable;
   assign busy     = (q.nv != TPDO_NV_IDLE);
   assign glob     = i_paddr[`TPDO_ADDR_GLOBAL_BIT];
   assign a_ch     = i_paddr[6:5];
   assign a_fld    = i_paddr[4:2];
   assign greg     = i_paddr[6:2];
   assign unmapped = glob ? (greg > `TPDO_GREG_STATUS)
                          : (a_fld == `TPDO_FLD_NONE);
   // The read data of the store lag the address by one cycle, so the
   // answer waits for one idle cycle after any save or restore.
   assign o_pready  = acc & ~busy & q.rd_ok;
   assign o_pslverr = o_pready & unmapped;
   assign wr        = o_pready & i_pwrite & ~unmapped;
   // The entry count ignores writes.
   assign ch_wr     = wr & ~glob & (a_fld != `TPDO_FLD_COUNT);
   assign nv_restore_wr = (q.nv == TPDO_NV_RS_WR);

   always_comb begin
      o_prdata = 32'h0000_0000;
      if (unmapped) begin
         o_prdata = 32'h0000_0000;
      end else if (!glob) begin
         o_prdata = m.rdata;
      end else if (greg == `TPDO_GREG_OVF) begin
         o_prdata = {24'h000000, q.ovf};
      end else if (greg == `TPDO_GREG_STATUS) begin
         o_prdata = {20'h00000, q.apend | q.spend | q.zpend,
                     q.started, 3'h0, busy};
      end
   end

   // ==========================================================================
   // Store access: restore writes and save reads take the port when busy
   assign m.we    = ch_wr | nv_restore_wr;
   assign m.wch   = nv_restore_wr ? q.nv_ch : a_ch;
   assign m.wfld  = nv_restore_wr ? q.nv_fld : a_fld;
   assign m.wdata = nv_restore_wr ? i_nv_rdata : i_pwdata;
   assign m.rch   = busy ? q.nv_ch : a_ch;
   assign m.rfld  = busy ? q.nv_fld : a_fld;

   assign o_nv_we    = (q.nv == TPDO_NV_ST_WR);
   assign o_nv_re    = (q.nv == TPDO_NV_RS_RD);
   assign o_nv_addr  = {q.nv_ch, q.nv_fld};
   assign o_nv_wdata = m.rdata;

   assign o_tx_valid = q.tx_valid;
   assign o_tx_chan  = q.tx_chan;
   assign o_tx_cob   = q.tx_cob;

   // ==========================================================================
   // Next state
   logic                 tick;
   logic                 ms_tick;
   logic                 nv_last;
   logic                 found;
   logic                 gate;
   logic [`TPDO_NCH-1:0] elig;

   assign tick    = (q.tick == 13'(P_TICK_CYC - 1));
   assign ms_tick = tick && (q.msdiv == 4'(`TPDO_MS_DIV - 1));
   assign nv_last = (q.nv_ch == `TPDO_NCH_LAST) &&
                    (q.nv_fld == `TPDO_FLD_SSTART);

   always_comb begin
      d     = q;
      found = 1'b0;
      gate  = 1'b0;
      elig  = '0;
      d.rd_ok = ~busy;

      // Shared time base: 100 us ticks and every tenth one a ms tick.
      d.tick = tick ? 13'h0000 : q.tick + 13'h0001;
      if (tick) begin
         d.msdiv = ms_tick ? 4'h0 : q.msdiv + 4'h1;
      end

      if (wr && glob && greg == `TPDO_GREG_OVF) begin
         d.ovf = i_pwdata[7:0];
      end

      // Save and restore walk fields 1..6 of every channel in turn.
      unique case (q.nv)
         TPDO_NV_IDLE: begin
            d.nv_ch  = 2'h0;
            d.nv_fld = `TPDO_FLD_COB;
            if (wr && glob && greg == `TPDO_GREG_CTRL) begin
               if (i_pwdata[`TPDO_CTRL_STORE]) begin
                  d.nv = TPDO_NV_ST_RD;
               end else if (i_pwdata[`TPDO_CTRL_RESTORE]) begin
                  d.nv = TPDO_NV_RS_RD;
               end
            end
         end
         TPDO_NV_ST_RD: d.nv = TPDO_NV_ST_WR;
         TPDO_NV_RS_RD: d.nv = TPDO_NV_RS_WR;
         TPDO_NV_ST_WR, TPDO_NV_RS_WR: begin
            if (nv_last) begin
               d.nv = TPDO_NV_IDLE;
            end else begin
               d.nv = (q.nv == TPDO_NV_ST_WR) ? TPDO_NV_ST_RD
                                              : TPDO_NV_RS_RD;
               if (q.nv_fld == `TPDO_FLD_SSTART) begin
                  d.nv_fld = `TPDO_FLD_COB;
                  d.nv_ch  = q.nv_ch + 2'h1;
               end else begin
                  d.nv_fld = q.nv_fld + 3'h1;
               end
            end
         end
         default: d.nv = TPDO_NV_IDLE;
      endcase

      // Send arbitration first, so that new events below win over the
      // clear of a pending bit in the same cycle.
      for (int i = 0; i < `TPDO_NCH; i++) begin
         // Sync sends pass regardless of the inhibit count.
         elig[i] = q.spend[i] | (q.apend[i] & (q.inh[i] == 17'h00000));
      end
      if (!q.tx_valid || i_tx_ready) begin
         d.tx_valid = 1'b0;
         for (int i = 0; i < `TPDO_NCH; i++) begin
            if (elig[i] && !found) begin
               found      = 1'b1;
               d.tx_valid = 1'b1;
               d.tx_chan  = 2'(i);
               d.tx_cob   = m.cob[i];
               if (q.spend[i]) begin
                  d.spend[i] = 1'b0;
               end else begin
                  d.apend[i] = 1'b0;
               end
               if (tt_async(m.ttype[i])) begin
                  // One extra tick so the gap is never short of the time.
                  d.inh[i] = (m.inh[i] == 16'h0000) ? 17'h00000
                           : {1'b0, m.inh[i]} + 17'h00001;
                  d.evt[i] = m.evt[i];
               end
            end
         end
      end

      // Per-channel triggers; every channel has its own counters.
      for (int i = 0; i < `TPDO_NCH; i++) begin
         if (tick && d.inh[i] != 17'h00000) begin
            d.inh[i] = d.inh[i] - 17'h00001;
         end
         if (tt_async(m.ttype[i]) && m.evt[i] != 16'h0000) begin
            if (ms_tick) begin
               if (d.evt[i] <= 16'h0001) begin
                  d.apend[i] = 1'b1;
                  d.evt[i]   = m.evt[i];
               end else begin
                  d.evt[i] = d.evt[i] - 16'h0001;
               end
            end
         end
         if (i_app_event[i]) begin
            if (tt_async(m.ttype[i])) begin
               d.apend[i] = 1'b1;
            end else if (m.ttype[i] == `TPDO_TT_ACYCLIC) begin
               d.zpend[i] = 1'b1;
            end
         end
         // A new start value waits for its count again; a match wins.
         if (m.we && m.wch == 2'(i) && m.wfld == `TPDO_FLD_SSTART) begin
            d.started[i] = 1'b0;
         end
         gate = (q.ovf > 8'h01) && (m.sstart[i] != 8'h00);
         if (i_sync && !tt_async(m.ttype[i])) begin
            if (gate && !q.started[i]) begin
               if (i_sync_count == m.sstart[i]) begin
                  d.started[i] = 1'b1;
                  d.scnt[i]    = 8'h00;
                  if (tt_cyclic(m.ttype[i]) || q.zpend[i]) begin
                     d.spend[i] = 1'b1;
                     d.zpend[i] = d.zpend[i] & i_app_event[i];
                  end
               end
            end else if (m.ttype[i] == `TPDO_TT_ACYCLIC) begin
               if (q.zpend[i]) begin
                  d.spend[i] = 1'b1;
                  d.zpend[i] = i_app_event[i];
               end
            end else if (tt_cyclic(m.ttype[i])) begin
               if (q.scnt[i] + 8'h01 >= m.ttype[i]) begin
                  d.spend[i] = 1'b1;
                  d.scnt[i]  = 8'h00;
               end else begin
                  d.scnt[i] = q.scnt[i] + 8'h01;
               end
            end
         end
      end

      if (i_reset) begin
         d     = '0;
         d.nv  = TPDO_NV_IDLE;
         d.nv_fld = `TPDO_FLD_COB;
         d.ovf = `TPDO_RST_OVF;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      q <= d;
   end

endmodule

// ---- tb/tpdo_comm_params_properties.sv ----
// Port-level checks for the transmit PDO parameter block.
`timescale 1ns/1ps

module tpdo_comm_params_properties (
   // Clock and reset
   input wire logic        i_ref_clk,
   input wire logic        i_reset,
   // APB
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [7:0]  i_paddr,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic [31:0] o_prdata,
   // Send and store
   input wire logic        i_tx_ready,
   input wire logic        o_tx_valid,
   input wire logic [1:0]  o_tx_chan,
   input wire logic [31:0] o_tx_cob,
   input wire logic        o_nv_we,
   input wire logic        o_nv_re,
   input wire logic [4:0]  o_nv_addr
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   logic acc;
   assign acc = i_psel && i_penable && o_pready && !i_paddr[7];

   a_err_with_ready: assert property (o_pslverr |-> o_pready)
      else $error("error flag without ready");
   a_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
      else $error("ready outside access phase");
   a_count_reads_six: assert property (acc && !i_pwrite &&
      i_paddr[4:2] == 3'h0 |-> o_prdata == 32'h0000_0006 && !o_pslverr)
      else $error("entry count not six");
   a_hole_refused: assert property (acc && i_paddr[4:2] == 3'h7
      |-> o_pslverr) else $error("record hole accepted");
   a_send_held: assert property (o_tx_valid && !i_tx_ready
      |=> o_tx_valid && $stable(o_tx_chan) && $stable(o_tx_cob))
      else $error("send request dropped or changed");
   a_nv_no_overlap: assert property (!(o_nv_we && o_nv_re))
      else $error("save and restore together");
   a_nv_word_once: assert property (o_nv_we |=> !o_nv_we)
      else $error("save strobe longer than one cycle");
   a_nv_stalls_bus: assert property (o_nv_we || o_nv_re |-> !o_pready)
      else $error("bus answered during store");
   a_nv_field_range: assert property (o_nv_we |->
      o_nv_addr[2:0] inside {[3'h1:3'h6]}) else $error("bad saved field");
   a_release_quiet: assert property ($fell(i_reset) |-> !o_tx_valid
      && !o_nv_we && !o_nv_re && o_nv_addr == 5'h01)
      else $error("outputs busy after reset");

   c_send: cover property (o_tx_valid && i_tx_ready);
   c_stall: cover property (o_tx_valid && !i_tx_ready);
   c_save: cover property (o_nv_we);
   c_restore: cover property (o_nv_re);
endmodule

// ---- tb/tpdo_partner.sv ----
// Frame sender and non-volatile store beside the parameter block.
`timescale 1ns/1ps

module tpdo_partner (
   // Clock
   input  wire logic        i_ref_clk,
   // Send request
   input  wire logic        i_tx_valid,
   input  wire logic [1:0]  i_tx_chan,
   input  wire logic [31:0] i_tx_cob,
   input  wire logic        i_slow,
   output logic             o_tx_ready,
   // Store
   input  wire logic        i_nv_we,
   input  wire logic        i_nv_re,
   input  wire logic [4:0]  i_nv_addr,
   input  wire logic [31:0] i_nv_wdata,
   output logic [31:0]      o_nv_rdata
);
   logic [31:0] mem [32];
   logic [1:0]  gap_q = 2'h0;
   logic [31:0] last_cob = 32'h0;
   int          sends [4] = '{0, 0, 0, 0};

   // A slow sender takes a request only every fourth cycle.
   assign o_tx_ready = !i_slow || gap_q == 2'h0;
   initial o_nv_rdata = 32'h0;

   always @(posedge i_ref_clk) begin
      gap_q <= gap_q + 2'h1;
      if (i_tx_valid && o_tx_ready) begin
         sends[i_tx_chan] <= sends[i_tx_chan] + 1;
         last_cob <= i_tx_cob;
      end
      if (i_nv_we) begin
         mem[i_nv_addr] <= i_nv_wdata;
      end
      // Outside its slot the word keeps toggling, so a late sample shows.
      o_nv_rdata <= i_nv_re ? mem[i_nv_addr] : ~o_nv_rdata;
   end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the transmit PDO parameter block.
`timescale 1ns/1ps

module tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        sync = 1'b0;
   logic [7:0]  scnt = 8'h00;
   logic [3:0]  ev = 4'h0;
   logic        slow = 1'b0;
   logic        pready, perr, tx_valid, tx_ready, nv_we, nv_re, e;
   logic [31:0] prdata, tx_cob, nv_wdata, nv_rdata, r;
   logic [1:0]  tx_chan;
   logic [4:0]  nv_addr;
   int          mismatches = 0;
   int          n_tests = 0;
   int          c, k, k0, s0;
   localparam logic [31:0] RV [7] = '{32'h6, 32'h0, 32'hFF, 32'h64,
                                      32'h0, 32'h0, 32'h0};

   initial forever #10 clk = ~clk;

   tpdo_comm_params #(.P_TICK_CYC(4)) i_tpdo_comm_params (
      .i_ref_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_pready(pready), .o_pslverr(perr), .o_prdata(prdata),
      .i_sync(sync), .i_sync_count(scnt), .i_app_event(ev),
      .o_tx_valid(tx_valid), .o_tx_chan(tx_chan), .o_tx_cob(tx_cob),
      .i_tx_ready(tx_ready), .o_nv_we(nv_we), .o_nv_re(nv_re),
      .o_nv_addr(nv_addr), .o_nv_wdata(nv_wdata), .i_nv_rdata(nv_rdata));

   tpdo_partner i_tpdo_partner (
      .i_ref_clk(clk), .i_tx_valid(tx_valid), .i_tx_chan(tx_chan),
      .i_tx_cob(tx_cob), .i_slow(slow), .o_tx_ready(tx_ready),
      .i_nv_we(nv_we), .i_nv_re(nv_re), .i_nv_addr(nv_addr),
      .i_nv_wdata(nv_wdata), .o_nv_rdata(nv_rdata));

   // ======================================================================
   // Tasks
   task automatic complete_run();
      if (mismatches == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got,
                      input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      logic ok;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      // Sampled mid-cycle, so these are the values that the next edge takes.
      do begin
         @(negedge clk);
         ok = (pready === 1'b1);
         r = prdata;
         e = perr;
         @(posedge clk);
         n++;
      end while (!ok && n < 300);
      psel <= 1'b0;
      pen <= 1'b0;
      if (n >= 300) begin
         mismatches++;
         complete_run();
      end
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rc(input string nm, input logic [7:0] a,
                     input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, r, exp);
   endtask

   task automatic wait_tx(input int ch, input int lim);
      k = i_tpdo_partner.sends[ch];
      c = 0;
      while (i_tpdo_partner.sends[ch] == k && c < lim) begin
         @(posedge clk);
         c++;
      end
      if (c >= lim) begin
         mismatches++;
         complete_run();
      end
   endtask

   task automatic pulse(input logic [3:0] m, input logic s,
                        input logic [7:0] v);
      ev <= m;
      sync <= s;
      scnt <= v;
      @(posedge clk);
      ev <= 4'h0;
      sync <= 1'b0;
      if (s) begin
         repeat (6) @(posedge clk);
      end
   endtask

   // ======================================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int ch = 0; ch < 4; ch++) begin
         for (int f = 0; f < 7; f++) begin
            rc("reset value", 8'(ch * 32 + f * 4), RV[f]);
         end
         wr(8'(ch * 32), 32'h9);
         wr(8'(ch * 32 + 4), 32'h8000_0180 + ch);
         wr(8'(ch * 32 + 16), 32'hFFFF_FF5A);
      end
      // Written all first, so a shared record would show here.
      for (int ch = 0; ch < 4; ch++) begin
         rc("entry count", 8'(ch * 32), 32'h6);
         rc("identifier", 8'(ch * 32 + 4), 32'h8000_0180 + ch);
         rc("compat", 8'(ch * 32 + 16), 32'h5A);
      end
      apb(1'b0, 8'h1C, 32'h0);
      chk("hole error", e, 1'b1);
      apb(1'b1, 8'h90, 32'h1);
      chk("global hole error", e, 1'b1);
      wr(8'h0C, 32'h3);
      pulse(4'h1, 1'b0, 8'h0);
      wait_tx(0, 20);
      chk("sent id", i_tpdo_partner.last_cob, 32'h8000_0180);
      pulse(4'h1, 1'b0, 8'h0);
      wait_tx(0, 100);
      chk("inhibit gap", c >= 10 && c <= 30, 1'b1);
      // An asynchronous send loads channel 1's inhibit count first.
      pulse(4'h2, 1'b0, 8'h0);
      wait_tx(1, 20);
      s0 = i_tpdo_partner.sends[0];
      slow <= 1'b1;
      wr(8'h28, 32'h1);
      k0 = i_tpdo_partner.sends[1];
      pulse(4'h0, 1'b1, 8'h1);
      pulse(4'h0, 1'b1, 8'h2);
      chk("sync sends", i_tpdo_partner.sends[1] - k0, 2);
      chk("async on sync", i_tpdo_partner.sends[0] - s0, 0);
      slow <= 1'b0;
      wr(8'h84, 32'h3);
      wr(8'h38, 32'h5);
      k0 = i_tpdo_partner.sends[1];
      for (int v = 3; v < 7; v++) begin
         pulse(4'h0, 1'b1, 8'(v));
         chk("sync start", i_tpdo_partner.sends[1] - k0,
             v < 5 ? 0 : v - 4);
      end
      wr(8'h84, 32'h1);
      wr(8'h38, 32'h9);
      k0 = i_tpdo_partner.sends[1];
      pulse(4'h0, 1'b1, 8'h2);
      chk("start inactive", i_tpdo_partner.sends[1] - k0, 1);
      wr(8'h48, 32'hFE);
      wr(8'h4C, 32'h0);
      wr(8'h54, 32'h1);
      wait_tx(2, 100);
      wait_tx(2, 100);
      chk("timer period", c >= 30 && c <= 50, 1'b1);
      wr(8'h54, 32'h0);
      repeat (10) @(posedge clk);
      k0 = i_tpdo_partner.sends[2];
      repeat (120) @(posedge clk);
      chk("timer off", i_tpdo_partner.sends[2] - k0, 0);
      wr(8'h64, 32'h283);
      wr(8'h80, 32'h1);
      apb(1'b0, 8'h88, 32'h0);
      chk("store busy", r[0], 1'b0);
      wr(8'h64, 32'h0);
      wr(8'h80, 32'h2);
      rc("restored id", 8'h64, 32'h283);
      rc("restored type", 8'h48, 32'hFE);
      complete_run();
   end
endmodule

bind tpdo_comm_params tpdo_comm_params_properties i_props (
   .i_ref_clk, .i_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr,
   .o_pready, .o_pslverr, .o_prdata, .i_tx_ready, .o_tx_valid,
   .o_tx_chan, .o_tx_cob, .o_nv_we, .o_nv_re, .o_nv_addr);
